/* design/spi_switch_pkg.sv */
// Shared constants and types for the serial switch command and diagnosis logic.
package spi_switch_pkg;

  // Channel organisation.
  localparam int CHANNELS = 16;
  localparam int HALF = 8;
  localparam int PAR_PER_HALF = 4;
  localparam int FRAME_BITS = 16;

  // Frame bit counter.
  localparam logic [4:0] BIT_CNT_RESET = 5'h00;
  localparam logic [4:0] BIT_CNT_FULL = 5'h10;
  localparam logic [4:0] BIT_CNT_MAX = 5'h1f;

  // Control byte fields: high nibble is the function, low nibble the half.
  localparam int CTRL_MSB = 15;
  localparam int CTRL_FUNC_LSB = 12;
  localparam int CTRL_SEL_MSB = 11;
  localparam int CTRL_SEL_LSB = 8;
  localparam int DATA_MSB = 7;
  localparam logic [3:0] SEL_LOWER = 4'h0;
  localparam logic [3:0] SEL_UPPER = 4'hf;
  localparam logic [3:0] FUNC_DIAG = 4'h0;
  localparam logic [3:0] FUNC_READ = 4'hc;
  localparam logic [3:0] FUNC_ECHO = 4'ha;
  localparam logic [3:0] FUNC_OR = 4'h3;
  localparam logic [3:0] FUNC_AND = 4'hf;

  // Two-bit channel diagnosis codes.
  localparam logic [1:0] CODE_NORMAL = 2'h3;
  localparam logic [1:0] CODE_LIMIT = 2'h2;
  localparam logic [1:0] CODE_OPEN = 2'h1;
  localparam logic [1:0] CODE_SHORT_GND = 2'h0;

  // Combining modes and values after reset.
  localparam logic MODE_OR = 1'b0;
  localparam logic MODE_AND = 1'b1;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic SYNC_RESET = 1'b0;

  // Settling wait the host keeps between the two identical frames.
  localparam int SETTLE_TIME_US = 150;
  localparam int CLK_PERIOD_NS = 25;
  localparam int SETTLE_CYCLES = (SETTLE_TIME_US * 1000) / CLK_PERIOD_NS;

  // Command remembered from the last accepted frame.
  typedef enum logic [2:0] {
    CMD_NONE = 3'b000,
    CMD_DIAG = 3'b001,
    CMD_READ = 3'b010,
    CMD_ECHO = 3'b011,
    CMD_OR = 3'b100,
    CMD_AND = 3'b101
  } cmd_e;

  // Link state.
  typedef enum logic [0:0] {
    LINK_IDLE = 1'b0,
    LINK_FRAME = 1'b1
  } link_e;

endpackage : spi_switch_pkg

/* design/pin_sync.sv */
// Two-flop synchroniser for a bundle of asynchronous pins.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic resetn,
  // Asynchronous side.
  input wire logic [WIDTH-1:0] async_i,
  // Synchronised side.
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] stable_q;
  logic [WIDTH-1:0] stable_d;

  // The first stage feeds only the second stage.
  always_comb begin
    meta_d = async_i;
    stable_d = meta_q;
  end

  // Both stages clear to low so no false falling edge is seen before pins settle.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      meta_q <= {WIDTH{spi_switch_pkg::SYNC_RESET}};
      stable_q <= {WIDTH{spi_switch_pkg::SYNC_RESET}};
    end else begin
      meta_q <= meta_d;
      stable_q <= stable_d;
    end
  end

  assign sync_o = stable_q;

endmodule : pin_sync

/* design/fault_latch.sv */
// Per-channel diagnosis register with half-wise clearing.
`timescale 1ns/1ps
module fault_latch #(
  parameter int CHANNELS = 16
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic resetn,
  // Live detector levels, one bit per channel.
  input wire logic [CHANNELS-1:0] limit_det,
  input wire logic [CHANNELS-1:0] open_det,
  input wire logic [CHANNELS-1:0] short_gnd_det,
  // One-cycle clear strobes for each half.
  input wire logic clear_lower,
  input wire logic clear_upper,
  // Latched two-bit codes, channel k at bits 2k+1:2k.
  output logic [2*CHANNELS-1:0] codes
);

  for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
    logic [1:0] code_q;
    logic [1:0] code_d;
    logic clear_this;

    assign clear_this = (i < CHANNELS / 2) ? clear_lower : clear_upper;

    // A live fault wins over a clear in the same cycle, so no event is lost.
    always_comb begin
      code_d = code_q;
      if (clear_this) begin
        code_d = spi_switch_pkg::CODE_NORMAL; // [R11] [R12]
      end
      if (limit_det[i]) begin
        code_d = spi_switch_pkg::CODE_LIMIT; // [R2] [R3] [R7]
      end else if (short_gnd_det[i]) begin
        code_d = spi_switch_pkg::CODE_SHORT_GND; // [R3] [R9]
      end else if (open_det[i]) begin
        code_d = spi_switch_pkg::CODE_OPEN; // [R3] [R8]
      end
    end

    // Codes hold until read out and cleared.
    always_ff @(posedge clk_sys) begin
      if (!resetn) begin
        code_q <= spi_switch_pkg::CODE_NORMAL; // [R6]
      end else begin
        code_q <= code_d;
      end
    end

    assign codes[2*i+1:2*i] = code_q;
  end

endmodule : fault_latch

/* design/spi_switch_diagnostics.sv */
// Serial command, output combining and diagnosis read-out of the sixteen channel switch.
// Behaviour
// (R1) Fault flag pulls low on any channel error.
// (R2) Channel fault code latched until read out.
// (R3) New error overwrites the previous channel code.
// (R4) Serial output released while chip select high.
// (R5) Diagnosis bits shift out during a selected frame.
// (R6) Code HH means channel normal.
// (R7) Code HL means current limitation active.
// (R8) Code LH means open load.
// (R9) Code LL means short to ground.
// (R10) Host repeats frame after settling to read.
// (R11) Reading clears diagnosis at chip select fall.
// (R12) Clear only the half previously addressed.
// (R13) OR command combines inputs, requests full diagnosis.
// (R14) AND command combines inputs, requests full diagnosis.
// (R15) Response appears in the following frame.
// (R16) Diagnosis only keeps outputs, ignores data.
// (R17) Read-back returns inputs then fault bits.
// (R18) Echo loops input to output next frame.
// (R19) Serial command sets selected half's outputs.
// (R20) Low control nibble selects the half.
// (R21) OR after reset; mode latched until changed.
// (R22) Unknown word: no action, next frame zeros.
// (R23) Frame after echo returns all zeros.
// (R24) Sixteen clocks, MSB first, control byte first.
`timescale 1ns/1ps
module spi_switch_diagnostics #(
  parameter int CHANNELS = 16
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic resetn,
  // Serial link pins.
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic si,
  output logic so_o,
  output logic so_oe,
  // Parallel inputs for channels 1 to 4 and 9 to 12.
  input wire logic [3:0] parallel_input_lower_first,
  input wire logic [3:0] parallel_input_upper_first,
  // Detector levels from the output stages.
  input wire logic [CHANNELS-1:0] limit_det,
  input wire logic [CHANNELS-1:0] open_det,
  input wire logic [CHANNELS-1:0] short_gnd_det,
  // Channel drive and open-drain fault flag.
  output logic [CHANNELS-1:0] chan_on,
  output logic fault_n_o,
  output logic fault_n_oe
);

  localparam int SYNC_W = 3 + 8 + 3 * CHANNELS;

  // Synchronised pins.
  logic [SYNC_W-1:0] sync_bus;
  logic cs_n_s;
  logic sclk_s;
  logic si_s;
  logic [7:0] par_s;
  logic [CHANNELS-1:0] lim_s;
  logic [CHANNELS-1:0] open_s;
  logic [CHANNELS-1:0] sgnd_s;
  logic [2*CHANNELS-1:0] codes;
  logic clear_lower;
  logic clear_upper;

  // State.
  spi_switch_pkg::link_e link_q, link_d;
  spi_switch_pkg::cmd_e pend_q, pend_d;
  logic pend_upper_q, pend_upper_d;
  logic cs_prev_q, cs_prev_d;
  logic sclk_prev_q, sclk_prev_d;
  logic [4:0] bit_cnt_q, bit_cnt_d;
  logic [15:0] rx_q, rx_d;
  logic [15:0] tx_q, tx_d;
  logic so_q, so_d;
  logic so_oe_q, so_oe_d;
  logic echo_q, echo_d;
  logic [1:0] mode_q, mode_d;
  logic [15:0] ser_q, ser_d;
  logic [CHANNELS-1:0] chan_q, chan_d;
  logic fault_oe_q, fault_oe_d;

  // Every pin from outside the clock domain passes two flops first.
  pin_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .async_i({cs_n, sclk, si, parallel_input_upper_first, parallel_input_lower_first,
              limit_det, open_det, short_gnd_det}),
    .sync_o(sync_bus)
  );

  assign {cs_n_s, sclk_s, si_s, par_s, lim_s, open_s, sgnd_s} = sync_bus;

  // Latched per-channel diagnosis.
  fault_latch #(
    .CHANNELS(CHANNELS)
  ) u_diag (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .limit_det(lim_s),
    .open_det(open_s),
    .short_gnd_det(sgnd_s),
    .clear_lower(clear_lower),
    .clear_upper(clear_upper),
    .codes(codes)
  );

  // Maps a control byte to a command; a bad half nibble makes it unknown.
  function automatic spi_switch_pkg::cmd_e decode_cmd(input logic [7:0] ctrl);
    logic [3:0] func;
    logic [3:0] sel;
    func = ctrl[7:4];
    sel = ctrl[3:0];
    decode_cmd = spi_switch_pkg::CMD_NONE;
    if (sel == spi_switch_pkg::SEL_LOWER || sel == spi_switch_pkg::SEL_UPPER) begin // [R20]
      if (func == spi_switch_pkg::FUNC_DIAG) begin
        decode_cmd = spi_switch_pkg::CMD_DIAG;
      end else if (func == spi_switch_pkg::FUNC_READ) begin
        decode_cmd = spi_switch_pkg::CMD_READ;
      end else if (func == spi_switch_pkg::FUNC_ECHO) begin
        decode_cmd = spi_switch_pkg::CMD_ECHO;
      end else if (func == spi_switch_pkg::FUNC_OR) begin
        decode_cmd = spi_switch_pkg::CMD_OR;
      end else if (func == spi_switch_pkg::FUNC_AND) begin
        decode_cmd = spi_switch_pkg::CMD_AND;
      end
    end
  endfunction : decode_cmd

  // Builds the word shifted out in the frame after a command.
  function automatic logic [15:0] build_resp(input spi_switch_pkg::cmd_e cmd,
                                             input logic upper,
                                             input logic [31:0] diag,
                                             input logic [7:0] par);
    logic [15:0] half_diag;
    logic [7:0] fbits;
    half_diag = upper ? diag[31:16] : diag[15:0];
    for (int k = 0; k < 8; k++) begin
      fbits[k] = &half_diag[2*k+:2];
    end
    build_resp = spi_switch_pkg::WORD_RESET; // [R22] [R23]
    case (cmd)
      spi_switch_pkg::CMD_DIAG,
      spi_switch_pkg::CMD_OR,
      spi_switch_pkg::CMD_AND: begin
        build_resp = half_diag; // [R6] [R13] [R14] [R16] [R19]
      end
      spi_switch_pkg::CMD_READ: begin
        build_resp = {par, fbits}; // [R17]
      end
      default: begin
        build_resp = spi_switch_pkg::WORD_RESET;
      end
    endcase
  endfunction : build_resp

  // Link, command and channel next-state logic.
  always_comb begin
    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic [7:0] ctrl;
    logic [7:0] data;
    logic upper;
    spi_switch_pkg::cmd_e cmd;
    cs_fall = cs_prev_q & ~cs_n_s;
    cs_rise = ~cs_prev_q & cs_n_s;
    sclk_rise = ~sclk_prev_q & sclk_s;
    sclk_fall = sclk_prev_q & ~sclk_s;
    ctrl = rx_q[spi_switch_pkg::CTRL_MSB:spi_switch_pkg::CTRL_SEL_LSB];
    data = rx_q[spi_switch_pkg::DATA_MSB:0];
    upper = (ctrl[3:0] == spi_switch_pkg::SEL_UPPER);
    cmd = decode_cmd(ctrl);
    link_d = link_q;
    pend_d = pend_q;
    pend_upper_d = pend_upper_q;
    cs_prev_d = cs_n_s;
    sclk_prev_d = sclk_s;
    bit_cnt_d = bit_cnt_q;
    rx_d = rx_q;
    tx_d = tx_q;
    so_d = so_q;
    so_oe_d = so_oe_q;
    echo_d = echo_q;
    mode_d = mode_q;
    ser_d = ser_q;
    clear_lower = 1'b0;
    clear_upper = 1'b0;
    if (cs_fall) begin
      // The answer to the previous command is frozen here, then that half is cleared.
      link_d = spi_switch_pkg::LINK_FRAME;
      bit_cnt_d = spi_switch_pkg::BIT_CNT_RESET;
      tx_d = build_resp(pend_q, pend_upper_q, codes, par_s); // [R15]
      echo_d = (pend_q == spi_switch_pkg::CMD_ECHO); // [R18]
      so_d = tx_d[15]; // [R24]
      so_oe_d = 1'b1; // [R5]
      if (pend_q != spi_switch_pkg::CMD_NONE && pend_q != spi_switch_pkg::CMD_ECHO) begin
        clear_lower = ~pend_upper_q; // [R11] [R12]
        clear_upper = pend_upper_q; // [R11] [R12]
      end
    end else if (link_q == spi_switch_pkg::LINK_FRAME) begin
      if (sclk_rise) begin
        rx_d = {rx_q[14:0], si_s}; // [R24]
        if (bit_cnt_q != spi_switch_pkg::BIT_CNT_MAX) begin
          bit_cnt_d = bit_cnt_q + 5'h01;
        end
      end
      if (sclk_fall) begin
        tx_d = {tx_q[14:0], 1'b0};
        so_d = tx_q[14]; // [R5]
      end
      if (echo_q) begin
        so_d = si_s; // [R18]
      end
      if (cs_rise) begin
        link_d = spi_switch_pkg::LINK_IDLE;
        so_oe_d = 1'b0; // [R4]
        echo_d = 1'b0;
        pend_d = spi_switch_pkg::CMD_NONE; // [R22] [R23]
        pend_upper_d = upper;
        // An echo frame is only looped back and never executed.
        if (!echo_q && bit_cnt_q == spi_switch_pkg::BIT_CNT_FULL) begin
          pend_d = cmd;
          if (cmd == spi_switch_pkg::CMD_OR || cmd == spi_switch_pkg::CMD_AND) begin
            mode_d[upper] = (cmd == spi_switch_pkg::CMD_AND) ? spi_switch_pkg::MODE_AND
                                                              : spi_switch_pkg::MODE_OR; // [R21]
            if (upper) begin
              ser_d[15:8] = data; // [R19]
            end else begin
              ser_d[7:0] = data; // [R19]
            end
          end
        end
      end
    end
  end

  // Channel drive: the first four channels of each half mix in their parallel pin.
  always_comb begin
    chan_d = ser_q;
    for (int h = 0; h < 2; h++) begin
      for (int k = 0; k < spi_switch_pkg::PAR_PER_HALF; k++) begin
        if (mode_q[h] == spi_switch_pkg::MODE_AND) begin
          chan_d[h*spi_switch_pkg::HALF+k] = ser_q[h*8+k] & par_s[h*4+k]; // [R14]
        end else begin
          chan_d[h*spi_switch_pkg::HALF+k] = ser_q[h*8+k] | par_s[h*4+k]; // [R13]
        end
      end
    end
    fault_oe_d = (|lim_s) | (|open_s) | (|sgnd_s) | ~(&codes); // [R1]
  end

  // All state registers.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      link_q <= spi_switch_pkg::LINK_IDLE;
      pend_q <= spi_switch_pkg::CMD_NONE;
      pend_upper_q <= 1'b0;
      cs_prev_q <= spi_switch_pkg::SYNC_RESET; // Matches the synchroniser: no false fall.
      sclk_prev_q <= 1'b0;
      bit_cnt_q <= spi_switch_pkg::BIT_CNT_RESET;
      rx_q <= spi_switch_pkg::WORD_RESET;
      tx_q <= spi_switch_pkg::WORD_RESET;
      so_q <= 1'b0;
      so_oe_q <= 1'b0;
      echo_q <= 1'b0;
      mode_q <= spi_switch_pkg::MODE_RESET; // [R21]
      ser_q <= spi_switch_pkg::WORD_RESET;
      chan_q <= '0;
      fault_oe_q <= 1'b0;
    end else begin
      link_q <= link_d;
      pend_q <= pend_d;
      pend_upper_q <= pend_upper_d;
      cs_prev_q <= cs_prev_d;
      sclk_prev_q <= sclk_prev_d;
      bit_cnt_q <= bit_cnt_d;
      rx_q <= rx_d;
      tx_q <= tx_d;
      so_q <= so_d;
      so_oe_q <= so_oe_d;
      echo_q <= echo_d;
      mode_q <= mode_d;
      ser_q <= ser_d;
      chan_q <= chan_d;
      fault_oe_q <= fault_oe_d;
    end
  end

  // Outputs straight from flops, except fault_n_o which is tied low; the fault pin only ever drives low.
  assign so_o = so_q;
  assign so_oe = so_oe_q;
  assign chan_on = chan_q;
  assign fault_n_o = 1'b0;
  assign fault_n_oe = fault_oe_q;

endmodule : spi_switch_diagnostics

/* sim/spi_switch_checker.sv */
// Port checks for the serial switch block.
`timescale 1ns/1ps
module spi_switch_checker #(
  parameter int CHANNELS = 16
) (
  // Clock, reset and link.
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic so_o,
  input wire logic so_oe,
  // Detectors and outputs.
  input wire logic [CHANNELS-1:0] limit_det,
  input wire logic [CHANNELS-1:0] open_det,
  input wire logic [CHANNELS-1:0] short_gnd_det,
  input wire logic [CHANNELS-1:0] chan_on,
  input wire logic fault_n_o,
  input wire logic fault_n_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // Five idle cycles cover the synchroniser lag after a rise.
  sequence cs_idle;
    cs_n [*5];
  endsequence
  sequence frame_open;
    $fell(cs_n) ##1 !cs_n;
  endsequence

  // Outputs settle idle one edge into reset.
  rst_state_a: assert property (disable iff (1'b0) !resetn |=> !so_oe && !fault_n_oe && chan_on == '0)
    else $error("outputs not idle in reset");
  idle_hiz_a: assert property (cs_idle |-> !so_oe)
    else $error("serial output driven while deselected");
  release_a: assert property ($rose(cs_n) |-> ##[1:5] !so_oe)
    else $error("serial output not released");
  frame_drive_a: assert property (frame_open |-> ##[0:4] so_oe)
    else $error("serial output not driven in frame");
  // The host samples on the rise, so the line must not move while the clock is high.
  so_steady_a: assert property (so_oe && $changed(so_o) |-> !sclk)
    else $error("serial output moved while clock high");
  fault_pull_a: assert property ((|limit_det || |open_det || |short_gnd_det) |-> ##[1:4] fault_n_oe)
    else $error("fault flag not pulled");
  drain_value_a: assert property (fault_n_oe |-> !fault_n_o)
    else $error("fault flag drives high");
  // The flag is let go only by a read clear, and that clear falls inside a frame.
  flag_release_a: assert property ($fell(fault_n_oe) |-> !cs_n)
    else $error("fault flag released outside a read frame");
  // A driven serial output must always start from a real chip-select fall.
  oe_rise_a: assert property ($rose(so_oe) |-> !cs_n)
    else $error("serial output driven without chip select");
  // Serial-only channels may change only after a frame has closed.
  drive_still_a: assert property ($changed({chan_on[15:12], chan_on[7:4]}) |-> $past(cs_n, 2))
    else $error("channel drive changed in frame");
endmodule : spi_switch_checker

bind spi_switch_diagnostics spi_switch_checker #(.CHANNELS(CHANNELS)) chk (
  .clk_sys, .resetn, .cs_n, .sclk, .so_o, .so_oe, .limit_det, .open_det,
  .short_gnd_det, .chan_on, .fault_n_o, .fault_n_oe
);

/* sim/spi_host.sv */
// Host controller model acting as master of the serial link.
`timescale 1ns/1ps
module spi_host (
  // Pacing clock.
  input wire logic clk_sys,
  // Link pins.
  output logic cs_n,
  output logic sclk,
  output logic si,
  input wire logic so_o,
  input wire logic so_oe
);
  // The link clock is parked low outside frames.
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
  end

  // Four system clocks give a 100 ns half period.
  task automatic half_wait();
    repeat (4) @(negedge clk_sys);
  endtask : half_wait

  // One frame of sixteen clocks; a released output reads as unknown.
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      si = tx[i];
      half_wait();
      rx[i] = so_oe ? so_o : 1'bx;
      sclk = 1'b1;
      half_wait();
      sclk = 1'b0;
    end
    half_wait();
    cs_n = 1'b1;
    si = ~si; // A released line must not keep its last value.
    repeat (10) @(negedge clk_sys);
  endtask : xfer
endmodule : spi_host

/* sim/tb_top.sv */
// Self-checking bench for the serial switch block.
`timescale 1ns/1ps
module tb_top;
  logic clk_sys;
  logic resetn;
  logic cs_n, sclk, si, so_o, so_oe;
  logic [3:0] par_lo, par_hi;
  logic [15:0] lim, opn, gnd, chan_on, rx;
  logic fault_n_o, fault_n_oe;
  int miscompares;
  int checks;

  // 40 MHz system clock.
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  spi_switch_diagnostics #(.CHANNELS(16)) dut (
    .clk_sys(clk_sys), .resetn(resetn), .cs_n(cs_n), .sclk(sclk), .si(si),
    .so_o(so_o), .so_oe(so_oe), .parallel_input_lower_first(par_lo),
    .parallel_input_upper_first(par_hi), .limit_det(lim), .open_det(opn),
    .short_gnd_det(gnd), .chan_on(chan_on), .fault_n_o(fault_n_o), .fault_n_oe(fault_n_oe)
  );

  spi_host host (
    .clk_sys(clk_sys), .cs_n(cs_n), .sclk(sclk), .si(si), .so_o(so_o), .so_oe(so_oe)
  );

  // Compare and count.
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Short detector pulse, long enough to pass the synchroniser.
  task automatic pulse(input logic [15:0] l, input logic [15:0] o, input logic [15:0] g);
    lim = l;
    opn = o;
    gnd = g;
    repeat (8) @(negedge clk_sys);
    lim = '0;
    opn = '0;
    gnd = '0;
    repeat (4) @(negedge clk_sys);
  endtask : pulse

  task automatic t_reset();
    check(chan_on, 16'h0000);
    check({15'h0, fault_n_oe}, 16'h0000);
    check({15'h0, so_oe}, 16'h0000);
  endtask : t_reset

  // Codes are latched, overwritten, and cleared half by half.
  task automatic t_diag();
    pulse(16'h0001, 16'h0002, 16'h0004);
    pulse(16'h0000, 16'h0008, 16'h0100);
    pulse(16'h0008, 16'h0000, 16'h0000);
    check({15'h0, fault_n_oe}, 16'h0001);
    host.xfer(16'h0000, rx);
    check(rx, 16'h0000);
    host.xfer(16'h0000, rx);
    check(rx, 16'hff86);
    host.xfer(16'h0f00, rx);
    check(rx, 16'hffff);
    host.xfer(16'h0f00, rx);
    check(rx, 16'hfffc);
    check({15'h0, fault_n_oe}, 16'h0000);
  endtask : t_diag

  // OR and AND combining per half, mode kept until changed.
  task automatic t_combine();
    par_lo = 4'h5;
    host.xfer(16'h3092, rx);
    check(chan_on, 16'h0097);
    host.xfer(16'hf092, rx);
    check(rx, 16'hffff);
    check(chan_on, 16'h0090);
    par_lo = 4'hf;
    repeat (6) @(negedge clk_sys);
    check(chan_on, 16'h0092);
    par_hi = 4'h3;
    host.xfer(16'h3f0c, rx);
    check(rx, 16'hffff);
    check(chan_on, 16'h0f92);
    host.xfer(16'h00ff, rx);
    check(chan_on, 16'h0f92);
    host.xfer(16'hff0c, rx);
    check(rx, 16'hffff);
    check(chan_on, 16'h0092);
    host.xfer(16'h3f0c, rx);
    check(rx, 16'hffff);
    check(chan_on, 16'h0f92);
  endtask : t_combine

  task automatic t_readback();
    host.xfer(16'hc000, rx);
    pulse(16'h0000, 16'h0000, 16'h0002);
    host.xfer(16'h0000, rx);
    check(rx, 16'h3ffd);
    check(chan_on, 16'h0f92);
    host.xfer(16'hcf00, rx);
    pulse(16'h8000, 16'h0000, 16'h0000);
    host.xfer(16'h0000, rx);
    check(rx, 16'h3f7f);
  endtask : t_readback

  // The looped frame carries a valid command that must not run.
  task automatic t_echo();
    host.xfer(16'ha000, rx);
    host.xfer(16'h3f55, rx);
    check(rx, 16'h3f55);
    check(chan_on, 16'h0f92);
    host.xfer(16'h0000, rx);
    check(rx, 16'h0000);
  endtask : t_echo

  task automatic t_unknown();
    host.xfer(16'h70ff, rx);
    check(chan_on, 16'h0f92);
    host.xfer(16'h35ff, rx);
    check(rx, 16'h0000);
    check(chan_on, 16'h0f92);
    host.xfer(16'h0000, rx);
    check(rx, 16'h0000);
  endtask : t_unknown

  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // Main sequence.
  initial begin
    resetn = 1'b0;
    par_lo = 4'h0;
    par_hi = 4'h0;
    lim = '0;
    opn = '0;
    gnd = '0;
    repeat (6) @(negedge clk_sys);
    resetn = 1'b1;
    repeat (4) @(negedge clk_sys);
    t_reset();
    t_diag();
    t_combine();
    t_readback();
    t_echo();
    t_unknown();
    report_and_stop();
  end

  // Watchdog: a hang counts as a mismatch.
  initial begin
    #1000000;
    miscompares++;
    report_and_stop();
  end
endmodule : tb_top
